/* src/ebps_pkg.sv */
// Functional notes
// - No-access mode opens only when a password is set and unlocked
// - Read-only mode reads unless locked, never writes
// - Read-write mode: locked blocks become read-only
// - Privileged flag refuses all user-mode accesses
// - Supply drop during programming flags failure
// - Forbidden write or second password flags denial
// - Copy-buffer move shown by status bit
// - Copy-buffer erase shown by status bit
// - Engine busy bit; no writes while set
// - Storage read during write flagged
// - Clean start reported when nothing interrupted
// - Recovered start reported, last write suspect
// - Unrecoverable start reported, may persist
// - One maskable program-done interrupt source
// - Hidden non-zero block inaccessible until reset
// - Lock relocks passworded block, else no effect
// - Locked block 0 shuts every other block
// - Lock state reads 1 unlocked, 0 locked
// - Size and block count readable, equal blocks
// - Byte offsets map to zero-based blocks
// - Password 1-3 words, not all-ones, once
// - Block protection ORed with block 0 flags
// - Unlock needs matching words and count
`default_nettype none
package ebps_pkg;
    // =====================================================
    // Geometry
    localparam int NB = 4;
    localparam int BLK_WORDS = 16;
    localparam int WORDS = NB * BLK_WORDS;
    localparam int AW = 8;
    localparam int BW = 2;
    localparam int SIZE_BYTES = WORDS * 4;
    localparam int BLK_BYTES = SIZE_BYTES / NB;
    // =====================================================
    // Register offsets
    localparam logic [7:0] OFS_SIZE = 8'h00;
    localparam logic [7:0] OFS_BLKCNT = 8'h04;
    localparam logic [7:0] OFS_BLKSEL = 8'h08;
    localparam logic [7:0] OFS_PROT = 8'h0C;
    localparam logic [7:0] OFS_KEY = 8'h10;
    localparam logic [7:0] OFS_CMD = 8'h14;
    localparam logic [7:0] OFS_LOCKST = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_IEN = 8'h20;
    localparam logic [7:0] OFS_ISTAT = 8'h24;
    localparam logic [7:0] OFS_DADDR = 8'h28;
    localparam logic [7:0] OFS_DATA = 8'h2C;
    // =====================================================
    // Field positions
    localparam int CMD_LOCK = 0;
    localparam int CMD_HIDE = 1;
    localparam int CMD_PWSET = 2;
    localparam int CMD_UNLOCK = 3;
    localparam int ST_WORK = 0;
    localparam int ST_COPY = 1;
    localparam int ST_ERASE = 2;
    localparam int ST_LV = 3;
    localparam int ST_DEN = 4;
    localparam int ST_RDW = 5;
    localparam int ST_INIT = 8;
    localparam int PRIV_BIT = 2;
    // =====================================================
    // Codes and reset values
    localparam logic [1:0] PROT_RW = 2'h0;
    localparam logic [1:0] PROT_NA = 2'h1;
    localparam logic [1:0] PROT_RO = 2'h2;
    localparam logic [1:0] INIT_OK = 2'h0;
    localparam logic [1:0] INIT_RETRY = 2'h1;
    localparam logic [1:0] INIT_ERROR = 2'h2;
    localparam logic [1:0] INIT_SAMPLE = 2'h2;
    // =====================================================
    // Timing
    localparam int CLK_MHZ = 25;
    localparam int COPY_NS = 120;
    localparam int ERASE_NS = 120;
    localparam int PROG_NS = 200;
    localparam logic [3:0] COPY_CYC = 4'((COPY_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] ERASE_CYC = 4'((ERASE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] PROG_CYC = 4'((PROG_NS * CLK_MHZ + 999) / 1000);
    // =====================================================
    // Types
    typedef enum logic [3:0] {
        ENG_IDLE = 4'h1,
        ENG_COPY = 4'h2,
        ENG_ERASE = 4'h4,
        ENG_PROG = 4'h8
    } ebps_eng_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } ebps_bus_t;
    typedef struct packed {
        ebps_eng_t state;
        logic [3:0] cnt;
        logic [NB-1:0][2:0] prot;
        logic [NB-1:0][2:0][31:0] pwd;
        logic [NB-1:0][1:0] pcnt;
        logic [NB-1:0] unl;
        logic [NB-1:0] hid;
        logic [2:0][31:0] ent;
        logic [1:0] ecnt;
        logic [BW-1:0] sel;
        logic [AW-1:0] daddr;
        logic [31:0] pdata;
        logic [AW-3:0] pidx;
        logic lvf;
        logic den;
        logic rdw;
        logic ipend;
        logic ien;
        logic irq;
        logic [31:0] rdata;
        logic [1:0] init;
        logic [1:0] icnt;
        logic lv1, lv2, nvi1, nvi2, nvr1, nvr2;
    } ebps_st_t;
endpackage : ebps_pkg
`default_nettype wire

/* src/ebps_core.sv */
// Added by the designer: strobed register access and the placing of the registers.
`default_nettype none
module ebps_core (
    input wire logic clk,
    input wire logic rst,
    input wire ebps_pkg::ebps_bus_t bus,
    input wire logic user_mode,
    input wire logic low_volt_pin,
    input wire logic nv_interrupted_pin,
    input wire logic nv_recovered_pin,
    output logic [31:0] rdata,
    output logic irq
);
    import ebps_pkg::*;

    ebps_st_t s, n;
    logic [31:0] mem [WORDS];
    logic [BW-1:0] blk;
    logic [AW-3:0] widx;
    logic [2:0] eprot;
    logic g0_locked, blocked, rd_ok, wr_ok, mem_we, pw_bad, pw_ok;
    logic [31:0] st_word;

    // =====================================================
    // Helpers
    function automatic logic [BW-1:0] blk_of(input logic [AW-1:0] a);
        return BW'(a / AW'(BLK_BYTES));
    endfunction : blk_of

    function automatic logic perm(input logic [2:0] p, input logic haspw,
                                  input logic unl, input logic wr, input logic usr);
        logic ok;
        logic locked;
        locked = haspw && !unl;
        case (p[1:0])
            PROT_RW: ok = !wr || !locked;
            PROT_NA: ok = haspw && unl;
            PROT_RO: ok = !wr && !locked;
            default: ok = 1'b0;
        endcase
        if (p[PRIV_BIT] && usr) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : perm

    // =====================================================
    // Access check, resolved before any storage touch
    always_comb begin
        blk = blk_of(s.daddr);
        widx = s.daddr[AW-1:2];
        eprot = (blk == '0) ? s.prot[0] : (s.prot[0] | s.prot[blk]);
        g0_locked = (s.pcnt[0] != 2'h0) && !s.unl[0];
        blocked = s.hid[blk] || ((blk != '0) && g0_locked);
        rd_ok = !blocked && perm(eprot, s.pcnt[blk] != 2'h0, s.unl[blk], 1'b0, user_mode);
        wr_ok = !blocked && perm(eprot, s.pcnt[blk] != 2'h0, s.unl[blk], 1'b1, user_mode);
        pw_bad = (s.ecnt == 2'h0) || (s.pcnt[s.sel] != 2'h0);
        pw_ok = (s.ecnt == s.pcnt[s.sel]) && (s.pcnt[s.sel] != 2'h0);
        for (int i = 0; i < 3; i++) begin
            if (i < int'(s.ecnt) && s.ent[i] == 32'hFFFF_FFFF) begin
                pw_bad = 1'b1;
            end
            if (i < int'(s.pcnt[s.sel]) && s.ent[i] != s.pwd[s.sel][i]) begin
                pw_ok = 1'b0;
            end
        end
        st_word = '0;
        st_word[ST_WORK] = s.state != ENG_IDLE;
        st_word[ST_COPY] = s.state == ENG_COPY;
        st_word[ST_ERASE] = s.state == ENG_ERASE;
        st_word[ST_LV] = s.lvf;
        st_word[ST_DEN] = s.den;
        st_word[ST_RDW] = s.rdw;
        st_word[ST_INIT+1:ST_INIT] = s.init;
    end

    // =====================================================
    // Next state: bus, engine, start-up report
    always_comb begin
        n = s;
        n.rdata = '0;
        mem_we = 1'b0;
        // Pins come from outside; two stages before use
        n.lv1 = low_volt_pin;
        n.lv2 = s.lv1;
        n.nvi1 = nv_interrupted_pin;
        n.nvi2 = s.nvi1;
        n.nvr1 = nv_recovered_pin;
        n.nvr2 = s.nvr1;
        // Start-up report latched once the pin samples settle
        if (s.icnt != INIT_SAMPLE + 2'h1) begin
            n.icnt = s.icnt + 2'h1;
            if (s.icnt == INIT_SAMPLE) begin
                if (!s.nvi2) begin
                    n.init = INIT_OK;
                end else if (s.nvr2) begin
                    n.init = INIT_RETRY;
                end else begin
                    n.init = INIT_ERROR;
                end
            end
        end
        // Register writes; clears come first so events below win
        if (bus.wr) begin
            case (bus.addr)
                OFS_BLKSEL: n.sel = bus.wdata[BW-1:0];
                OFS_PROT: begin
                    if (s.hid[s.sel] || (s.sel != '0 && g0_locked)) begin
                        n.den = 1'b1;
                    end else begin
                        n.prot[s.sel] = bus.wdata[2:0];
                    end
                end
                OFS_KEY: begin
                    if (s.ecnt != 2'h3) begin
                        n.ent[s.ecnt] = bus.wdata;
                        n.ecnt = s.ecnt + 2'h1;
                    end
                end
                OFS_CMD: begin
                    if (bus.wdata[CMD_LOCK] && s.pcnt[s.sel] != 2'h0) begin
                        n.unl[s.sel] = 1'b0;
                    end
                    if (bus.wdata[CMD_HIDE] && s.sel != '0) begin
                        n.hid[s.sel] = 1'b1;
                    end
                    if (bus.wdata[CMD_PWSET]) begin
                        n.ecnt = 2'h0;
                        if (pw_bad) begin
                            n.den = 1'b1;
                        end else begin
                            n.pwd[s.sel] = s.ent;
                            n.pcnt[s.sel] = s.ecnt;
                            n.unl[s.sel] = 1'b1;
                        end
                    end
                    if (bus.wdata[CMD_UNLOCK]) begin
                        n.ecnt = 2'h0;
                        if (pw_ok) begin
                            n.unl[s.sel] = 1'b1;
                        end
                    end
                end
                OFS_STATUS: begin
                    n.lvf = s.lvf & ~bus.wdata[ST_LV];
                    n.den = s.den & ~bus.wdata[ST_DEN];
                    n.rdw = s.rdw & ~bus.wdata[ST_RDW];
                end
                OFS_IEN: n.ien = bus.wdata[0];
                OFS_ISTAT: n.ipend = s.ipend & ~bus.wdata[0];
                OFS_DADDR: n.daddr = bus.wdata[AW-1:0];
                OFS_DATA: begin
                    // A write while busy is dropped: the requester must wait
                    if (s.state == ENG_IDLE) begin
                        if (!wr_ok) begin
                            n.den = 1'b1;
                        end else begin
                            n.pdata = bus.wdata;
                            n.pidx = widx;
                            n.state = ENG_COPY;
                            n.cnt = COPY_CYC - 4'h1;
                        end
                    end
                end
                default: ;
            endcase
        end
        // Register reads, data valid the cycle after the strobe
        if (bus.rd) begin
            case (bus.addr)
                OFS_SIZE: n.rdata = 32'(SIZE_BYTES);
                OFS_BLKCNT: n.rdata = 32'(NB);
                OFS_BLKSEL: n.rdata = 32'(s.sel);
                OFS_PROT: n.rdata = 32'(s.prot[s.sel]);
                OFS_LOCKST: n.rdata = 32'(s.pcnt[s.sel] == 2'h0 || s.unl[s.sel]);
                OFS_STATUS: n.rdata = st_word;
                OFS_IEN: n.rdata = 32'(s.ien);
                OFS_ISTAT: n.rdata = 32'(s.ipend);
                OFS_DADDR: n.rdata = 32'(s.daddr);
                OFS_DATA: begin
                    if (s.state != ENG_IDLE) begin
                        n.rdw = 1'b1;
                    end else if (rd_ok) begin
                        n.rdata = mem[widx];
                    end
                end
                default: n.rdata = '0;
            endcase
        end
        // Programming engine: copy, erase, then program the cell
        case (s.state)
            ENG_IDLE: ;
            ENG_COPY: begin
                n.cnt = s.cnt - 4'h1;
                if (s.cnt == 4'h0) begin
                    n.state = ENG_ERASE;
                    n.cnt = ERASE_CYC - 4'h1;
                end
            end
            ENG_ERASE: begin
                n.cnt = s.cnt - 4'h1;
                if (s.cnt == 4'h0) begin
                    n.state = ENG_PROG;
                    n.cnt = PROG_CYC - 4'h1;
                end
            end
            ENG_PROG: begin
                n.cnt = s.cnt - 4'h1;
                if (s.lv2) begin
                    n.lvf = 1'b1;
                    n.state = ENG_IDLE;
                end else if (s.cnt == 4'h0) begin
                    mem_we = 1'b1;
                    n.ipend = 1'b1;
                    n.state = ENG_IDLE;
                end
            end
            default: n.state = ENG_IDLE;
        endcase
        n.irq = n.ipend & n.ien;
    end

    // =====================================================
    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.state <= ENG_IDLE;
        end else begin
            s <= n;
        end
    end

    // Storage has no reset; contents are the point
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[s.pidx] <= s.pdata;
        end
    end

    assign rdata = s.rdata;
    assign irq = s.irq;

    // =====================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_LAUNCH_PERM: assert property (
        s.state == ENG_IDLE && n.state == ENG_COPY |-> wr_ok)
        else $error("write launched without permission");
    AST_DENY: assert property (
        bus.wr && bus.addr == OFS_DATA && s.state == ENG_IDLE && !wr_ok
        |=> s.den && s.state == ENG_IDLE)
        else $error("denied write not flagged");
    AST_PRIV: assert property (
        bus.rd && bus.addr == OFS_DATA && user_mode && eprot[PRIV_BIT] |=> rdata == 32'h0000_0000)
        else $error("user access reached privileged block");
    AST_LV: assert property (
        s.state == ENG_PROG && s.lv2 |=> s.lvf && s.state == ENG_IDLE && !$past(mem_we))
        else $error("supply drop not reported");
    AST_SEQ: assert property (
        $rose(s.state == ENG_COPY) |-> (s.state == ENG_COPY)[*3] ##1 (s.state == ENG_ERASE)[*3])
        else $error("copy or erase phase length wrong");
    AST_BUSY_DROP: assert property (
        bus.wr && bus.addr == OFS_DATA && s.state != ENG_IDLE |=> $stable(s.pdata))
        else $error("write accepted while busy");
    AST_RDW: assert property (
        bus.rd && bus.addr == OFS_DATA && s.state != ENG_IDLE |=> s.rdw && rdata == 32'h0000_0000)
        else $error("read during write not flagged");
    AST_G0: assert property (
        bus.rd && bus.addr == OFS_DATA && blk != '0 && g0_locked |=> rdata == 32'h0000_0000)
        else $error("block 0 lock ignored");
    AST_UNLOCK: assert property (
        bus.wr && bus.addr == OFS_CMD && bus.wdata[CMD_UNLOCK] && !pw_ok && !bus.wdata[CMD_PWSET]
        |=> s.unl[$past(s.sel)] == $past(s.unl[s.sel]))
        else $error("bad password unlocked block");
    AST_LOCK_NOPW: assert property (
        bus.wr && bus.addr == OFS_CMD && s.pcnt[s.sel] == 2'h0 && !bus.wdata[CMD_PWSET]
        |=> s.unl == $past(s.unl) || $past(bus.wdata[CMD_UNLOCK]))
        else $error("lock changed passwordless block");
    AST_IRQ: assert property (
        mem_we && s.ien |=> irq ##1 (irq || !s.ipend || !s.ien))
        else $error("program done interrupt missing");

    COV_PROG: cover property (s.state == ENG_PROG ##1 s.ipend);
    COV_DENY: cover property ($rose(s.den));
    COV_UNLOCK: cover property (bus.wr && bus.addr == OFS_CMD && bus.wdata[CMD_UNLOCK] && pw_ok);
    COV_RDW: cover property ($rose(s.rdw));
endmodule : ebps_core
`default_nettype wire

/* bench/ebps_core_tb.sv */
`default_nettype none
module ebps_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ebps_pkg::*;

    // =====================================================
    // Stimulus signals and unit under test
    logic clk;
    logic rst;
    ebps_bus_t bus;
    logic user_mode;
    logic low_volt_pin;
    logic nv_interrupted_pin;
    logic nv_recovered_pin;
    logic [31:0] rdata;
    logic irq;
    int fail_count = 0;
    int samples_checked = 0;
    logic [31:0] s;

    ebps_core uut (
        .clk(clk),
        .rst(rst),
        .bus(bus),
        .user_mode(user_mode),
        .low_volt_pin(low_volt_pin),
        .nv_interrupted_pin(nv_interrupted_pin),
        .nv_recovered_pin(nv_recovered_pin),
        .rdata(rdata),
        .irq(irq)
    );

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // =====================================================
    // Compare, bus and closing tasks
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // One-cycle strobes; idle cycle between requests keeps drivers simple
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        d = rdata;
    endtask : rd

    // Bounded poll on the busy bit; a hang ends the run
    task automatic wait_idle();
        logic [31:0] st;
        int n;
        n = 0;
        do begin
            rd(OFS_STATUS, st);
            n++;
        end while (st[ST_WORK] !== 1'b0 && n < 40);
        if (st[ST_WORK] !== 1'b0) begin
            fail_count++;
            give_verdict();
        end
    endtask : wait_idle

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : do_reset

    // Storage write, then one status bit judged and error bits cleared
    task automatic try_wr(input logic [7:0] a, input logic [31:0] d, input int b, input logic e);
        logic [31:0] st;
        wr(OFS_DADDR, {24'h00_0000, a});
        wr(OFS_DATA, d);
        wait_idle();
        rd(OFS_STATUS, st);
        chk1(st[b], e);
        wr(OFS_STATUS, 32'h0000_0038);
    endtask : try_wr

    task automatic try_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        wr(OFS_DADDR, {24'h00_0000, a});
        rd(OFS_DATA, d);
        chk32(d, e);
    endtask : try_rd

    // =====================================================
    // Scenarios
    task automatic t_reset_values();
        rd(OFS_SIZE, s); chk32(s, 32'h0000_0100);
        rd(OFS_BLKCNT, s); chk32(s, 32'h0000_0004);
        rd(OFS_LOCKST, s); chk32(s, 32'h0000_0001);
        rd(OFS_STATUS, s); chk32(s, 32'h0000_0000);
        rd(8'h30, s); chk32(s, 32'h0000_0000);
    endtask : t_reset_values

    // Engine phases seen by back-to-back status reads
    task automatic t_program_walk();
        wr(OFS_IEN, 32'h0000_0001);
        wr(OFS_DADDR, 32'h0000_0004);
        wr(OFS_DATA, 32'hA5A5_0001);
        rd(OFS_STATUS, s); chk32(s, 32'h0000_0003);
        rd(OFS_STATUS, s); chk32(s, 32'h0000_0005);
        rd(OFS_DATA, s); chk32(s, 32'h0000_0000);
        wr(OFS_DATA, 32'hFFFF_0003);
        wait_idle();
        rd(OFS_STATUS, s); chk1(s[ST_RDW], 1'b1);
        chk1(irq, 1'b1);
        rd(OFS_ISTAT, s); chk32(s, 32'h0000_0001);
        wr(OFS_ISTAT, 32'h0000_0001);
        rd(OFS_ISTAT, s); chk32(s, 32'h0000_0000);
        chk1(irq, 1'b0);
        wr(OFS_STATUS, 32'h0000_0038);
        try_rd(8'h04, 32'hA5A5_0001);
        wr(OFS_IEN, 32'h0000_0000);
        try_wr(8'h44, 32'h5A5A_0002, ST_DEN, 1'b0);
        chk1(irq, 1'b0);
        rd(OFS_ISTAT, s); chk32(s, 32'h0000_0001);
        wr(OFS_ISTAT, 32'h0000_0001);
    endtask : t_program_walk

    task automatic t_modes();
        wr(OFS_BLKSEL, 32'h0000_0001);
        wr(OFS_PROT, 32'h0000_0002);
        try_wr(8'h44, 32'h7777_0006, ST_DEN, 1'b1);
        try_rd(8'h44, 32'h5A5A_0002);
        wr(OFS_PROT, 32'h0000_0004);
        @(posedge clk) user_mode <= 1'b1;
        try_rd(8'h44, 32'h0000_0000);
        @(posedge clk) user_mode <= 1'b0;
        try_rd(8'h44, 32'h5A5A_0002);
        wr(OFS_BLKSEL, 32'h0000_0003);
        wr(OFS_PROT, 32'h0000_0001);
        try_wr(8'hC4, 32'h3333_0007, ST_DEN, 1'b1);
        try_rd(8'hC4, 32'h0000_0000);
        wr(OFS_PROT, 32'h0000_0000);
        try_wr(8'hC4, 32'h3333_0007, ST_DEN, 1'b0);
        try_rd(8'hC4, 32'h3333_0007);
        wr(OFS_BLKSEL, 32'h0000_0000);
        wr(OFS_PROT, 32'h0000_0002);
        try_wr(8'h48, 32'h4444_0008, ST_DEN, 1'b1);
        wr(OFS_PROT, 32'h0000_0000);
    endtask : t_modes

    // Password life cycle on block 2, then hiding it
    task automatic t_password();
        wr(OFS_BLKSEL, 32'h0000_0002);
        try_wr(8'h84, 32'hC0DE_0004, ST_DEN, 1'b0);
        wr(OFS_KEY, 32'h1234_5678);
        wr(OFS_KEY, 32'h0BAD_F00D);
        wr(OFS_CMD, 32'h0000_0004);
        rd(OFS_LOCKST, s); chk32(s, 32'h0000_0001);
        wr(OFS_CMD, 32'h0000_0001);
        rd(OFS_LOCKST, s); chk32(s, 32'h0000_0000);
        try_rd(8'h84, 32'hC0DE_0004);
        try_wr(8'h84, 32'hDEAD_0005, ST_DEN, 1'b1);
        wr(OFS_KEY, 32'h1234_5678);
        wr(OFS_CMD, 32'h0000_0008);
        rd(OFS_LOCKST, s); chk32(s, 32'h0000_0000);
        wr(OFS_KEY, 32'h1234_5678);
        wr(OFS_KEY, 32'h0BAD_F00D);
        wr(OFS_CMD, 32'h0000_0008);
        rd(OFS_LOCKST, s); chk32(s, 32'h0000_0001);
        wr(OFS_KEY, 32'h0000_0099);
        wr(OFS_CMD, 32'h0000_0004);
        rd(OFS_STATUS, s); chk1(s[ST_DEN], 1'b1);
        wr(OFS_STATUS, 32'h0000_0038);
        wr(OFS_BLKSEL, 32'h0000_0001);
        // All-ones key word must be refused and leave no password behind
        wr(OFS_KEY, 32'hFFFF_FFFF);
        wr(OFS_CMD, 32'h0000_0004);
        rd(OFS_STATUS, s); chk1(s[ST_DEN], 1'b1);
        wr(OFS_STATUS, 32'h0000_0038);
        wr(OFS_CMD, 32'h0000_0001);
        rd(OFS_LOCKST, s); chk32(s, 32'h0000_0001);
        wr(OFS_BLKSEL, 32'h0000_0002);
        wr(OFS_CMD, 32'h0000_0002);
        try_rd(8'h84, 32'h0000_0000);
        try_wr(8'h84, 32'hDEAD_0005, ST_DEN, 1'b1);
    endtask : t_password

    task automatic t_block0_lock();
        wr(OFS_BLKSEL, 32'h0000_0000);
        wr(OFS_KEY, 32'h0000_0A0A);
        wr(OFS_CMD, 32'h0000_0004);
        wr(OFS_CMD, 32'h0000_0001);
        rd(OFS_LOCKST, s); chk32(s, 32'h0000_0000);
        try_rd(8'hC4, 32'h0000_0000);
        try_wr(8'hC4, 32'h3333_0009, ST_DEN, 1'b1);
        wr(OFS_KEY, 32'h0000_0A0A);
        wr(OFS_CMD, 32'h0000_0008);
        try_rd(8'hC4, 32'h3333_0007);
        // Hiding block 0 is ignored; it stays reachable
        wr(OFS_CMD, 32'h0000_0002);
        try_rd(8'h04, 32'hA5A5_0001);
    endtask : t_block0_lock

    task automatic t_low_volt();
        @(posedge clk) low_volt_pin <= 1'b1;
        try_wr(8'hC8, 32'h6666_000A, ST_LV, 1'b1);
        @(posedge clk) low_volt_pin <= 1'b0;
        try_wr(8'hC8, 32'h6666_000A, ST_LV, 1'b0);
        try_rd(8'hC8, 32'h6666_000A);
    endtask : t_low_volt

    // Start-up report for each of the three outcomes; resets wipe settings
    task automatic t_start_report();
        @(posedge clk) nv_interrupted_pin <= 1'b1;
        nv_recovered_pin <= 1'b1;
        do_reset();
        rd(OFS_STATUS, s); chk32({30'h0, s[9:8]}, {30'h0, INIT_RETRY});
        @(posedge clk) nv_recovered_pin <= 1'b0;
        do_reset();
        rd(OFS_STATUS, s); chk32({30'h0, s[9:8]}, {30'h0, INIT_ERROR});
        @(posedge clk) nv_interrupted_pin <= 1'b0;
        do_reset();
        rd(OFS_STATUS, s); chk32({30'h0, s[9:8]}, {30'h0, INIT_OK});
    endtask : t_start_report

    // =====================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        bus = '0;
        user_mode = 1'b0;
        low_volt_pin = 1'b0;
        nv_interrupted_pin = 1'b0;
        nv_recovered_pin = 1'b0;
        do_reset();
        t_reset_values();
        t_program_walk();
        t_modes();
        t_password();
        t_block0_lock();
        t_low_volt();
        t_start_report();
        give_verdict();
    end
endmodule : ebps_core_tb
`default_nettype wire
